/* hdl/ufm_endpoint_fifo.v */
// endpoint 1-5 fifo buffering, packet handshakes and axi4-lite register file
`timescale 1ns/1ps
`include "ufm_defines.vh"
// How it works
// [R1] regions of 32,64,128,256,512 bytes
// [R2] firmware keeps both max sizes within region
// [R3] single: in from top down, out up
// [R4] second buffers start at midpoint, opposite directions
// [R5] firmware zeroes unused direction max size
// [R6] double buffer enable bits give two packets
// [R7] data write pushes in, read pops out
// [R8] double buffered in_packet_ready reads back cleared
// [R9] in_buffer_occupied shows any packet held
// [R10] arming with nothing loaded sends zlp
// [R11] out packet sets ready, flag, byte count
// [R12] release shows next packet; both-occupied status
// [R13] auto release after max out bytes read
// [R14] auto arm after max in bytes written
// [R15] in flag: sent, stalled or flushed
// [R16] out flag: received or stalled
// [R17] force_toggle flips toggle without ack
// [R18] in stall answers stall, sets sent
// [R19] out stall discards packet, answers stall
// [R20] iso in starved sends zlp, flags
// [R21] hold iso in packet until sof
// [R22] iso endpoints ignore stall requests
// [R23] sender splits long bulk transfers itself
// [R24] firmware selects endpoint before indexed access
// [R25] iso bit picks iso or bulk behaviour
module ufm_endpoint_fifo (
	input wire ref_clk,
	input wire rst,
	input wire clk_en,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire sof,
	input wire tok_in,
	input wire tok_out,
	input wire [2:0] tok_ep,
	output wire tok_ans_valid,
	output wire [1:0] tok_ans_code,
	output wire [9:0] tx_len,
	output wire tx_toggle,
	input wire tx_rd,
	output wire [7:0] tx_data,
	output wire tx_data_valid,
	input wire tx_end,
	input wire tx_acked,
	input wire rx_byte_valid,
	input wire [7:0] rx_byte,
	input wire rx_end,
	input wire rx_ok,
	output wire rx_ans_valid,
	output wire [1:0] rx_ans_code
);
	localparam RX_IDLE = 4'b0001;
	localparam RX_TAKE = 4'b0010;
	localparam RX_STALL = 4'b0100;
	localparam RX_DROP = 4'b1000;

	function [9:0] ufm_size;
		input [2:0] i;
		begin
			ufm_size = `UFM_EP1_SIZE << i; // R1
		end
	endfunction

	function [9:0] ufm_in_addr;
		input [2:0] i;
		input b;
		input [9:0] n;
		reg [9:0] s;
		begin
			s = ufm_size(i);
			ufm_in_addr = s - `UFM_EP1_SIZE + (b ? (s >> 1) : s) - 10'h001 - n; // R3 R4
		end
	endfunction

	function [9:0] ufm_out_addr;
		input [2:0] i;
		input b;
		input [9:0] n;
		reg [9:0] s;
		begin
			s = ufm_size(i);
			ufm_out_addr = s - `UFM_EP1_SIZE + (b ? (s >> 1) : 10'h000) + n; // R3 R4
		end
	endfunction

	function ufm_ep_ok;
		input [2:0] n;
		begin
			ufm_ep_ok = (n != 3'h0) && (n <= 3'h5);
		end
	endfunction

	reg [7:0] mem_reg [0:`UFM_MEM_BYTES-1];
	reg [9:0] max_in_reg [0:4];
	reg [9:0] max_out_reg [0:4];
	reg [9:0] in_len0_reg [0:4];
	reg [9:0] in_len1_reg [0:4];
	reg [9:0] out_len0_reg [0:4];
	reg [9:0] out_len1_reg [0:4];
	reg [9:0] wcnt_reg [0:4];
	reg [9:0] rcnt_reg [0:4];
	reg [4:0] in_dbl_reg, out_dbl_reg, in_iso_reg, out_iso_reg, frc_tog_reg, auto_arm_reg;
	reg [4:0] auto_rel_reg, in_stall_req_reg, in_stall_sent_reg, starved_reg;
	reg [4:0] out_stall_req_reg, out_stall_sent_reg, in_full0_reg, in_full1_reg;
	reg [4:0] in_fill_reg, in_send_reg, in_tog_reg, sof_ok_reg;
	reg [4:0] out_full0_reg, out_full1_reg, out_wsel_reg, out_rsel_reg;
	reg [4:0] in_flag_reg, out_flag_reg;
	reg [2:0] sel_reg;
	reg hold_sof_reg;
	reg awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	reg [1:0] bresp_reg, rresp_reg;
	reg [31:0] rdata_reg;
	reg tok_ans_valid_reg, tx_toggle_reg, tx_data_valid_reg, rx_ans_valid_reg, tx_live_reg;
	reg [1:0] tok_ans_code_reg, rx_ans_code_reg;
	reg [9:0] tx_len_reg, tx_idx_reg, rx_cnt_reg;
	reg [7:0] tx_data_reg;
	reg [2:0] tx_ep_reg, rx_ep_reg;
	reg [3:0] rx_mode_reg;
	integer k;

	wire wr_take = s_axi_awvalid & s_axi_wvalid & awready_reg & wready_reg;
	wire rd_take = s_axi_arvalid & arready_reg;
	wire [7:0] wa = s_axi_awaddr;
	wire [7:0] ra = s_axi_araddr;
	wire [31:0] wd = s_axi_wdata;
	wire we0 = wr_take & s_axi_wstrb[0];
	wire sel_ok = ufm_ep_ok(sel_reg); // R24
	wire [2:0] si = sel_reg - 3'h1;
	wire w_fifo = (wa[7:5] == `UFM_A_FIFO) && ufm_ep_ok(wa[4:2]);
	wire r_fifo = (ra[7:5] == `UFM_A_FIFO) && ufm_ep_ok(ra[4:2]);
	wire [2:0] pe = wa[4:2] - 3'h1;
	wire [2:0] qe = ra[4:2] - 3'h1;
	wire push_go = we0 & w_fifo; // R7
	wire q_rdy = out_rsel_reg[qe] ? out_full1_reg[qe] : out_full0_reg[qe];
	wire pop_go = rd_take & r_fifo & q_rdy; // R7
	wire [9:0] push_a = ufm_in_addr(pe, in_fill_reg[pe], wcnt_reg[pe]);
	wire [9:0] pop_a = ufm_out_addr(qe, out_rsel_reg[qe], rcnt_reg[qe]);
	wire rx_wr = rx_byte_valid & (rx_mode_reg == RX_TAKE) & (rx_cnt_reg < max_out_reg[rx_ep_reg]);
	wire [9:0] rx_a = ufm_out_addr(rx_ep_reg, out_wsel_reg[rx_ep_reg], rx_cnt_reg);
	wire [2:0] te = tok_ep - 3'h1;
	wire tok_ok = ufm_ep_ok(tok_ep);
	wire tx_rdy = (in_send_reg[te] ? in_full1_reg[te] : in_full0_reg[te]) &
		(~(hold_sof_reg & in_iso_reg[te]) | sof_ok_reg[te]); // R21
	wire arm_auto = push_go & auto_arm_reg[pe] & (wcnt_reg[pe] + 10'h001 == max_in_reg[pe]); // R14
	wire arm_man = we0 & (wa == `UFM_A_ICSL) & sel_ok & wd[`UFM_B_PKT_RDY] & ~wd[`UFM_B_FLUSH];
	wire [2:0] arm_e = arm_auto ? pe : si;
	wire [9:0] arm_n = arm_auto ? wcnt_reg[pe] + 10'h001 : wcnt_reg[si]; // R10
	wire arm_b = in_fill_reg[arm_e];
	wire arm_go = (arm_auto | arm_man) & ~(arm_b ? in_full1_reg[arm_e] : in_full0_reg[arm_e]);
	wire rel_auto = pop_go & auto_rel_reg[qe] & (rcnt_reg[qe] + 10'h001 == max_out_reg[qe]); // R13
	wire s_rdy = out_rsel_reg[si] ? out_full1_reg[si] : out_full0_reg[si];
	wire rel_man = we0 & (wa == `UFM_A_OCSL) & sel_ok & ~wd[`UFM_B_PKT_RDY] & s_rdy;
	wire [2:0] rel_e = rel_auto ? qe : si;
	wire rel_b = out_rsel_reg[rel_e];
	wire rel_next = rel_b ? out_full0_reg[rel_e] : out_full1_reg[rel_e];
	wire w_map = w_fifo || (wa[7:6] == 2'h0 && wa[1:0] == 2'h0 && wa <= `UFM_A_CNTH);

	reg [31:0] rd_word;
	reg rd_err;
	always @* begin
		rd_word = 32'h0000_0000;
		rd_err = 1'b0;
		case (ra)
			`UFM_A_SEL: rd_word[2:0] = sel_reg;
			`UFM_A_POW: rd_word[`UFM_B_HOLD_SOF] = hold_sof_reg;
			`UFM_A_IIF: rd_word[5:1] = in_flag_reg;
			`UFM_A_OIF: rd_word[5:1] = out_flag_reg;
			`UFM_A_MAXI: if (sel_ok) rd_word[9:0] = max_in_reg[si];
			`UFM_A_ICSL: if (sel_ok) begin
				rd_word[`UFM_B_PKT_RDY] = in_dbl_reg[si] ? (in_full0_reg[si] & in_full1_reg[si]) :
					in_full0_reg[si]; // R8
				rd_word[`UFM_B_OCCUPIED] = in_full0_reg[si] | in_full1_reg[si]; // R9
				rd_word[`UFM_B_STARVED] = starved_reg[si];
				rd_word[`UFM_B_STALL_REQ] = in_stall_req_reg[si];
				rd_word[`UFM_B_STALL_SENT] = in_stall_sent_reg[si];
				rd_word[6] = in_tog_reg[si];
			end
			`UFM_A_ICSH: if (sel_ok)
				rd_word[3:0] = {in_iso_reg[si], auto_arm_reg[si], in_dbl_reg[si], frc_tog_reg[si]};
			`UFM_A_MAXO: if (sel_ok) rd_word[9:0] = max_out_reg[si];
			`UFM_A_OCSL: if (sel_ok) begin
				rd_word[`UFM_B_PKT_RDY] = s_rdy; // R11
				rd_word[`UFM_B_OCCUPIED] = out_full0_reg[si] & out_full1_reg[si]; // R12
				rd_word[`UFM_B_STALL_REQ] = out_stall_req_reg[si];
				rd_word[`UFM_B_STALL_SENT] = out_stall_sent_reg[si];
			end
			`UFM_A_OCSH: if (sel_ok)
				rd_word[3:0] = {out_iso_reg[si], 1'b0, out_dbl_reg[si], auto_rel_reg[si]};
			`UFM_A_CNTL: if (sel_ok)
				rd_word[7:0] = out_rsel_reg[si] ? out_len1_reg[si][7:0] : out_len0_reg[si][7:0]; // R11
			`UFM_A_CNTH: if (sel_ok)
				rd_word[1:0] = out_rsel_reg[si] ? out_len1_reg[si][9:8] : out_len0_reg[si][9:8];
			default: begin
				if (r_fifo) begin
					if (q_rdy) rd_word[7:0] = mem_reg[pop_a]; // R7
				end else begin
					rd_err = 1'b1;
				end
			end
		endcase
	end

	always @(posedge ref_clk) begin
		if (clk_en) begin
			if (push_go) mem_reg[push_a] <= wd[7:0]; // R7
			if (rx_wr) mem_reg[rx_a] <= rx_byte; // R2 R5
		end
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (k = 0; k < `UFM_EP_COUNT; k = k + 1) begin
				max_in_reg[k] <= `UFM_RST_MAX;
				max_out_reg[k] <= `UFM_RST_MAX;
				in_len0_reg[k] <= `UFM_RST_MAX;
				in_len1_reg[k] <= `UFM_RST_MAX;
				out_len0_reg[k] <= `UFM_RST_MAX;
				out_len1_reg[k] <= `UFM_RST_MAX;
				wcnt_reg[k] <= `UFM_RST_MAX;
				rcnt_reg[k] <= `UFM_RST_MAX;
			end
			{in_dbl_reg, out_dbl_reg, in_iso_reg, out_iso_reg} <= {4{`UFM_RST_BITS}};
			{frc_tog_reg, auto_arm_reg, auto_rel_reg, starved_reg} <= {4{`UFM_RST_BITS}};
			{in_stall_req_reg, in_stall_sent_reg} <= {2{`UFM_RST_BITS}};
			{out_stall_req_reg, out_stall_sent_reg} <= {2{`UFM_RST_BITS}};
			{in_full0_reg, in_full1_reg, in_fill_reg, in_send_reg} <= {4{`UFM_RST_BITS}};
			{in_tog_reg, sof_ok_reg, in_flag_reg, out_flag_reg} <= {4{`UFM_RST_BITS}};
			{out_full0_reg, out_full1_reg, out_wsel_reg, out_rsel_reg} <= {4{`UFM_RST_BITS}};
			sel_reg <= 3'h0;
			hold_sof_reg <= 1'b0;
			{awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg} <= 5'h00;
			bresp_reg <= `UFM_RESP_OKAY;
			rresp_reg <= `UFM_RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			{tok_ans_valid_reg, tx_toggle_reg, tx_data_valid_reg} <= 3'h0;
			{rx_ans_valid_reg, tx_live_reg} <= 2'h0;
			tok_ans_code_reg <= `UFM_ANS_NAK;
			rx_ans_code_reg <= `UFM_ANS_NAK;
			{tx_len_reg, tx_idx_reg, rx_cnt_reg} <= 30'h0;
			tx_data_reg <= 8'h00;
			tx_ep_reg <= 3'h0;
			rx_ep_reg <= 3'h0;
			rx_mode_reg <= RX_IDLE;
		end else if (clk_en) begin
			awready_reg <= s_axi_awvalid & s_axi_wvalid & ~awready_reg & ~bvalid_reg;
			wready_reg <= s_axi_awvalid & s_axi_wvalid & ~awready_reg & ~bvalid_reg;
			arready_reg <= s_axi_arvalid & ~arready_reg & ~rvalid_reg;
			if (wr_take) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= w_map ? `UFM_RESP_OKAY : `UFM_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
			if (rd_take) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_word;
				rresp_reg <= rd_err ? `UFM_RESP_SLVERR : `UFM_RESP_OKAY;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
			tok_ans_valid_reg <= 1'b0;
			tx_data_valid_reg <= 1'b0;
			rx_ans_valid_reg <= 1'b0;
			if (we0) begin
				case (wa)
					`UFM_A_SEL: sel_reg <= wd[2:0]; // R24
					`UFM_A_POW: hold_sof_reg <= wd[`UFM_B_HOLD_SOF];
					`UFM_A_IIF: in_flag_reg <= in_flag_reg & ~wd[5:1];
					`UFM_A_OIF: out_flag_reg <= out_flag_reg & ~wd[5:1];
					`UFM_A_MAXI: if (sel_ok) max_in_reg[si] <= wd[9:0];
					`UFM_A_MAXO: if (sel_ok) max_out_reg[si] <= wd[9:0];
					`UFM_A_ICSL: if (sel_ok) begin
						in_stall_req_reg[si] <= wd[`UFM_B_STALL_REQ];
						if (!wd[`UFM_B_STALL_SENT]) in_stall_sent_reg[si] <= 1'b0;
						if (!wd[`UFM_B_STARVED]) starved_reg[si] <= 1'b0;
						if (wd[`UFM_B_FLUSH]) begin
							in_full0_reg[si] <= 1'b0;
							in_full1_reg[si] <= 1'b0;
							in_fill_reg[si] <= 1'b0;
							in_send_reg[si] <= 1'b0;
							wcnt_reg[si] <= `UFM_RST_MAX;
							in_flag_reg[si] <= 1'b1; // R15
						end
					end
					`UFM_A_ICSH: if (sel_ok) begin
						frc_tog_reg[si] <= wd[`UFM_B_FRC_TOG];
						in_dbl_reg[si] <= wd[`UFM_B_DBL]; // R6
						auto_arm_reg[si] <= wd[`UFM_B_AUTO];
						in_iso_reg[si] <= wd[`UFM_B_ISO]; // R25
					end
					`UFM_A_OCSL: if (sel_ok) begin
						out_stall_req_reg[si] <= wd[`UFM_B_STALL_REQ];
						if (!wd[`UFM_B_STALL_SENT]) out_stall_sent_reg[si] <= 1'b0;
					end
					`UFM_A_OCSH: if (sel_ok) begin
						auto_rel_reg[si] <= wd[`UFM_B_FRC_TOG];
						out_dbl_reg[si] <= wd[`UFM_B_DBL]; // R6
						out_iso_reg[si] <= wd[`UFM_B_ISO]; // R25
					end
					default: ;
				endcase
			end
			if (push_go) wcnt_reg[pe] <= wcnt_reg[pe] + 10'h001;
			if (arm_go) begin
				if (arm_b) begin
					in_full1_reg[arm_e] <= 1'b1;
					in_len1_reg[arm_e] <= arm_n;
				end else begin
					in_full0_reg[arm_e] <= 1'b1;
					in_len0_reg[arm_e] <= arm_n; // R10
				end
				wcnt_reg[arm_e] <= `UFM_RST_MAX;
				if (in_dbl_reg[arm_e]) in_fill_reg[arm_e] <= ~arm_b; // R6 R8
			end
			if (pop_go) rcnt_reg[qe] <= rcnt_reg[qe] + 10'h001;
			if (rel_auto | rel_man) begin
				if (rel_b) out_full1_reg[rel_e] <= 1'b0;
				else out_full0_reg[rel_e] <= 1'b0;
				rcnt_reg[rel_e] <= `UFM_RST_MAX;
				if (out_dbl_reg[rel_e]) begin
					out_rsel_reg[rel_e] <= ~rel_b;
					if (rel_next) out_flag_reg[rel_e] <= 1'b1; // R12
				end
			end
			if (sof) sof_ok_reg <= 5'h1F; // R21
			if (tok_in && tok_ok) begin
				tok_ans_valid_reg <= 1'b1;
				tx_ep_reg <= te;
				tx_idx_reg <= `UFM_RST_MAX;
				tx_toggle_reg <= in_tog_reg[te];
				tx_len_reg <= `UFM_RST_MAX;
				tx_live_reg <= 1'b0;
				if (!in_iso_reg[te] && in_stall_req_reg[te]) begin
					tok_ans_code_reg <= `UFM_ANS_STALL; // R18 R22
					in_stall_sent_reg[te] <= 1'b1;
					in_flag_reg[te] <= 1'b1; // R15
				end else if (tx_rdy) begin
					tok_ans_code_reg <= `UFM_ANS_DATA;
					tx_len_reg <= in_send_reg[te] ? in_len1_reg[te] : in_len0_reg[te];
					tx_live_reg <= 1'b1;
				end else if (in_iso_reg[te]) begin
					tok_ans_code_reg <= `UFM_ANS_DATA; // R20
					starved_reg[te] <= 1'b1;
					in_flag_reg[te] <= 1'b1;
				end else begin
					tok_ans_code_reg <= `UFM_ANS_NAK;
				end
			end
			if (tx_rd) begin
				tx_data_reg <= mem_reg[ufm_in_addr(tx_ep_reg, in_send_reg[tx_ep_reg], tx_idx_reg)];
				tx_data_valid_reg <= 1'b1;
				tx_idx_reg <= tx_idx_reg + 10'h001;
			end
			if (tx_end) begin
				tx_live_reg <= 1'b0;
				if (tx_live_reg && (tx_acked || in_iso_reg[tx_ep_reg])) begin
					if (in_send_reg[tx_ep_reg]) in_full1_reg[tx_ep_reg] <= 1'b0;
					else in_full0_reg[tx_ep_reg] <= 1'b0;
					if (in_dbl_reg[tx_ep_reg]) in_send_reg[tx_ep_reg] <= ~in_send_reg[tx_ep_reg];
					sof_ok_reg[tx_ep_reg] <= 1'b0; // R21
					in_flag_reg[tx_ep_reg] <= 1'b1; // R15
				end
				if (tx_live_reg && !in_iso_reg[tx_ep_reg] && (tx_acked || frc_tog_reg[tx_ep_reg]))
					in_tog_reg[tx_ep_reg] <= ~in_tog_reg[tx_ep_reg]; // R17
			end
			if (tok_out && tok_ok) begin
				rx_ep_reg <= te;
				rx_cnt_reg <= `UFM_RST_MAX;
				if (!out_iso_reg[te] && out_stall_req_reg[te])
					rx_mode_reg <= RX_STALL; // R19 R22
				else if (!(out_wsel_reg[te] ? out_full1_reg[te] : out_full0_reg[te]))
					rx_mode_reg <= RX_TAKE;
				else
					rx_mode_reg <= RX_DROP;
			end
			if (rx_wr) rx_cnt_reg <= rx_cnt_reg + 10'h001;
			if (rx_end) begin
				rx_ans_valid_reg <= 1'b1;
				rx_mode_reg <= RX_IDLE;
				case (rx_mode_reg)
					RX_STALL: begin
						rx_ans_code_reg <= `UFM_ANS_STALL; // R19
						out_stall_sent_reg[rx_ep_reg] <= 1'b1;
						out_flag_reg[rx_ep_reg] <= 1'b1; // R16
					end
					RX_TAKE: begin
						if (rx_ok) begin
							rx_ans_code_reg <= `UFM_ANS_DATA;
							if (out_wsel_reg[rx_ep_reg]) begin
								out_full1_reg[rx_ep_reg] <= 1'b1;
								out_len1_reg[rx_ep_reg] <= rx_cnt_reg;
							end else begin
								out_full0_reg[rx_ep_reg] <= 1'b1;
								out_len0_reg[rx_ep_reg] <= rx_cnt_reg; // R11
							end
							if (out_dbl_reg[rx_ep_reg])
								out_wsel_reg[rx_ep_reg] <= ~out_wsel_reg[rx_ep_reg]; // R6
							if (!(out_rsel_reg[rx_ep_reg] ? out_full1_reg[rx_ep_reg] :
								out_full0_reg[rx_ep_reg]))
								out_flag_reg[rx_ep_reg] <= 1'b1; // R11 R16
						end else begin
							rx_ans_code_reg <= `UFM_ANS_NONE;
						end
					end
					RX_DROP: rx_ans_code_reg <= `UFM_ANS_NAK;
					default: rx_ans_code_reg <= `UFM_ANS_NONE;
				endcase
			end
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign tok_ans_valid = tok_ans_valid_reg;
	assign tok_ans_code = tok_ans_code_reg;
	assign tx_len = tx_len_reg;
	assign tx_toggle = tx_toggle_reg;
	assign tx_data = tx_data_reg;
	assign tx_data_valid = tx_data_valid_reg;
	assign rx_ans_valid = rx_ans_valid_reg;
	assign rx_ans_code = rx_ans_code_reg;
endmodule // ufm_endpoint_fifo

/* pkg/ufm_defines.vh */
// register offsets, field positions, sizes and answer codes of the endpoint fifo block
`ifndef UFM_DEFINES_VH
`define UFM_DEFINES_VH
`define UFM_A_SEL 8'h00
`define UFM_A_POW 8'h04
`define UFM_A_IIF 8'h08
`define UFM_A_OIF 8'h0C
`define UFM_A_MAXI 8'h10
`define UFM_A_ICSL 8'h14
`define UFM_A_ICSH 8'h18
`define UFM_A_MAXO 8'h1C
`define UFM_A_OCSL 8'h20
`define UFM_A_OCSH 8'h24
`define UFM_A_CNTL 8'h28
`define UFM_A_CNTH 8'h2C
`define UFM_A_FIFO 3'h2
`define UFM_B_PKT_RDY 0
`define UFM_B_OCCUPIED 1
`define UFM_B_STARVED 2
`define UFM_B_FLUSH 3
`define UFM_B_STALL_REQ 4
`define UFM_B_STALL_SENT 5
`define UFM_B_FRC_TOG 0
`define UFM_B_DBL 1
`define UFM_B_AUTO 2
`define UFM_B_ISO 3
`define UFM_B_HOLD_SOF 0
`define UFM_EP1_SIZE 10'h020
`define UFM_MEM_BYTES 992
`define UFM_EP_COUNT 5
`define UFM_RST_BITS 5'h00
`define UFM_RST_MAX 10'h000
`define UFM_ANS_NAK 2'h0
`define UFM_ANS_DATA 2'h1
`define UFM_ANS_STALL 2'h2
`define UFM_ANS_NONE 2'h3
`define UFM_RESP_OKAY 2'h0
`define UFM_RESP_SLVERR 2'h2
`endif

/* verif/tb_top.sv */
// self-checking bench for the endpoint fifo block
`timescale 1ns/1ps
`include "ufm_defines.vh"
module tb_top;
	logic ref_clk, rst, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic sof, tok_in, tok_out, tok_ans_valid, tx_toggle, tx_rd, tx_data_valid, tx_end;
	logic tx_acked, rx_byte_valid, rx_end, rx_ok, rx_ans_valid;
	logic [7:0] s_axi_awaddr, s_axi_araddr, tx_data, rx_byte;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
	logic [31:0] b [0:7];
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, tok_ans_code, rx_ans_code, rrs, brs;
	logic [2:0] tok_ep;
	logic [9:0] tx_len;
	int n_fail, total_checks, cycles, seed, i, k, n;
	ufm_endpoint_fifo u_ufm_endpoint_fifo (.ref_clk, .rst, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sof, .tok_in, .tok_out, .tok_ep, .tok_ans_valid,
		.tok_ans_code, .tx_len, .tx_toggle, .tx_rd, .tx_data, .tx_data_valid, .tx_end, .tx_acked,
		.rx_byte_valid, .rx_byte, .rx_end, .rx_ok, .rx_ans_valid, .rx_ans_code);
	ufm_host_model u_ufm_host_model (.ref_clk, .tok_in, .tok_out, .tok_ep, .tok_ans_valid,
		.tok_ans_code, .tx_len, .tx_rd, .tx_data, .tx_data_valid, .tx_end, .tx_acked, .rx_byte_valid,
		.rx_byte, .rx_end, .rx_ok, .rx_ans_valid, .rx_ans_code);
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_code(input string nm, input logic [1:0] e, input logic [1:0] g);
		chk(nm, {30'h0, e}, {30'h0, g});
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge ref_clk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_wdata <= ~d;
		if ($random(seed) & 1)
			@(posedge ref_clk);
		s_axi_bready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
		brs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		if ($random(seed) & 1)
			@(posedge ref_clk);
		s_axi_rready <= 1'b1;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
		rdv = s_axi_rdata;
		rrs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
		axr(a);
		chk(nm, e, rdv & m);
	endtask
	function automatic logic [7:0] fifo_a(input int ep);
		return 8'h44 + 8'(4 * (ep - 1));
	endfunction
	function automatic logic [31:0] ep_flag(input int ep);
		return 32'h1 << ep;
	endfunction
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			test_done;
		end
	end
	initial begin
		seed = 16450;
		{rst, clk_en, sof, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 6'h30;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rdc("icsl_reset", `UFM_A_ICSL, 32'h7F, 32'h0);
		axr(8'h30);
		chk_code("unmapped", `UFM_RESP_SLVERR, rrs);
		axw(8'h30, 32'h0);
		chk_code("unmapped_w", `UFM_RESP_SLVERR, brs);
		$display("test reset done");
		axw(`UFM_A_SEL, 32'h2);
		chk_code("sel_resp", `UFM_RESP_OKAY, brs);
		axw(`UFM_A_MAXO, 32'h0);
		axw(`UFM_A_MAXI, 32'h3);
		for (i = 0; i < 3; i++) begin
			b[i] = $random(seed) & 32'hFF;
			axw(fifo_a(2), b[i]);
		end
		axw(`UFM_A_ICSL, 32'h1);
		rdc("occupied", `UFM_A_ICSL, 32'h2, 32'h2);
		u_ufm_host_model.in_tx(3'h2, 1'b1, $random(seed) & 3);
		chk_code("in_ans", `UFM_ANS_DATA, u_ufm_host_model.ans_code);
		chk("tx_len", 32'h3, u_ufm_host_model.ans_len);
		for (i = 0; i < 3; i++)
			chk("tx_byte", b[i], u_ufm_host_model.rxq[i]);
		rdc("in_flag", `UFM_A_IIF, 32'h3E, ep_flag(2));
		$display("test in_data done");
		axw(`UFM_A_IIF, 32'h3E);
		axw(`UFM_A_ICSH, 32'h1);
		axw(`UFM_A_ICSL, 32'h1);
		u_ufm_host_model.in_tx(3'h2, 1'b0, 0);
		chk_code("zlp_ans", `UFM_ANS_DATA, u_ufm_host_model.ans_code);
		chk("zlp_len", 32'h0, u_ufm_host_model.ans_len);
		chk("tx_toggle", 32'h1, {31'h0, tx_toggle});
		rdc("forced_toggle", `UFM_A_ICSL, 32'h40, 32'h0);
		u_ufm_host_model.in_tx(3'h2, 1'b1, 0);
		axw(`UFM_A_ICSL, 32'h10);
		u_ufm_host_model.in_tx(3'h2, 1'b1, 0);
		chk_code("stall_ans", `UFM_ANS_STALL, u_ufm_host_model.ans_code);
		rdc("stall_sent", `UFM_A_ICSL, 32'h20, 32'h20);
		axw(`UFM_A_ICSL, 32'h0);
		$display("test in_zlp_stall done");
		axw(`UFM_A_SEL, 32'h3);
		axw(`UFM_A_ICSH, 32'h8);
		axw(`UFM_A_ICSL, 32'h10);
		u_ufm_host_model.in_tx(3'h3, 1'b1, 0);
		chk_code("iso_ans", `UFM_ANS_DATA, u_ufm_host_model.ans_code);
		chk("iso_len", 32'h0, u_ufm_host_model.ans_len);
		rdc("starved", `UFM_A_ICSL, 32'h24, 32'h04);
		axw(`UFM_A_POW, 32'h1);
		axw(fifo_a(3), 32'h3C);
		axw(`UFM_A_ICSL, 32'h1);
		u_ufm_host_model.in_tx(3'h3, 1'b1, 0);
		chk("held_len", 32'h0, u_ufm_host_model.ans_len);
		sof <= 1'b1;
		@(posedge ref_clk);
		sof <= 1'b0;
		u_ufm_host_model.in_tx(3'h3, 1'b1, 0);
		chk("sof_len", 32'h1, u_ufm_host_model.ans_len);
		$display("test iso_in done");
		axw(`UFM_A_SEL, 32'h1);
		axw(`UFM_A_MAXO, 32'h8);
		for (k = 0; k < 2; k++) begin
			axw(`UFM_A_OCSH, 32'(k));
			n = k ? 8 : 1 + ($random(seed) & 3);
			u_ufm_host_model.txq.delete();
			for (i = 0; i < n; i++) begin
				b[i] = $random(seed) & 32'hFF;
				u_ufm_host_model.txq.push_back(b[i][7:0]);
			end
			u_ufm_host_model.out_tx(3'h1, 1'b1);
			chk_code("out_ans", 2'h1, u_ufm_host_model.ans_code);
			rdc("out_ready", `UFM_A_OCSL, 32'h1, 32'h1);
			rdc("rx_count", `UFM_A_CNTL, 32'hFF, 32'(n));
			rdc("out_flag", `UFM_A_OIF, 32'h3E, ep_flag(1));
			axw(`UFM_A_OIF, 32'h3E);
			for (i = 0; i < n; i++)
				rdc("out_byte", fifo_a(1), 32'hFF, b[i]);
			if (k == 0)
				axw(`UFM_A_OCSL, 32'h0);
			rdc("released", `UFM_A_OCSL, 32'h1, 32'h0);
		end
		axw(`UFM_A_OCSL, 32'h10);
		u_ufm_host_model.out_tx(3'h1, 1'b1);
		chk_code("out_stall", `UFM_ANS_STALL, u_ufm_host_model.ans_code);
		rdc("out_stalled", `UFM_A_OCSL, 32'h21, 32'h20);
		$display("test out done");
		axw(`UFM_A_SEL, 32'h4);
		axw(`UFM_A_MAXI, 32'h2);
		axw(`UFM_A_ICSH, 32'h4);
		axw(fifo_a(4), 32'hA5);
		rdc("not_armed", `UFM_A_ICSL, 32'h1, 32'h0);
		axw(fifo_a(4), 32'h5A);
		rdc("auto_armed", `UFM_A_ICSL, 32'h3, 32'h3);
		$display("test auto_arm done");
		test_done;
	end
endmodule // tb_top

/* verif/ufm_chk.sv */
// port assertions for the endpoint fifo block
`timescale 1ns/1ps
module ufm_chk (
	input wire ref_clk,
	input wire rst,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire tok_in,
	input wire [2:0] tok_ep,
	input wire tok_ans_valid,
	input wire tx_rd,
	input wire tx_data_valid,
	input wire rx_end,
	input wire rx_ans_valid
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_tok;
		tok_in && tok_ep inside {[3'h1:3'h5]};
	endsequence
	sequence s_wr_ans;
		s_axi_wready ##1 (s_axi_bvalid && !s_axi_awready);
	endsequence
	a_write_pair: assert property (s_axi_awready |-> s_wr_ans)
		else $error("write handshake pair broken");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp))
		else $error("write response moved");
	a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data moved");
	a_tok_answer: assert property (s_tok |=> tok_ans_valid)
		else $error("token not answered");
	a_ans_pulse: assert property (tok_ans_valid && !tok_in |=> !tok_ans_valid)
		else $error("token answer too long");
	a_txd_next: assert property (tx_rd |=> tx_data_valid)
		else $error("tx byte missing");
	a_rx_answer: assert property (rx_end |=> rx_ans_valid)
		else $error("rx handshake missing");
endmodule // ufm_chk

bind ufm_endpoint_fifo ufm_chk u_chk (.ref_clk, .rst, .s_axi_awready, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .tok_in, .tok_ep, .tok_ans_valid, .tx_rd, .tx_data_valid, .rx_end,
	.rx_ans_valid);

/* verif/ufm_host_model.sv */
// usb engine model: issues tokens, drains in packets, feeds out packets
`timescale 1ns/1ps
module ufm_host_model (
	input wire ref_clk,
	output logic tok_in,
	output logic tok_out,
	output logic [2:0] tok_ep,
	input wire tok_ans_valid,
	input wire [1:0] tok_ans_code,
	input wire [9:0] tx_len,
	output logic tx_rd,
	input wire [7:0] tx_data,
	input wire tx_data_valid,
	output logic tx_end,
	output logic tx_acked,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic rx_end,
	output logic rx_ok,
	input wire rx_ans_valid,
	input wire [1:0] rx_ans_code
);
	logic [1:0] ans_code;
	logic [31:0] ans_len;
	logic [31:0] rxq [$];
	logic [7:0] txq [$];
	initial begin
		{tok_in, tok_out, tx_rd, tx_end, tx_acked, rx_byte_valid, rx_end, rx_ok} = 8'h00;
		tok_ep = 3'h0;
		rx_byte = 8'h00;
	end
	task automatic in_tx(input logic [2:0] ep, input logic ack, input int gap);
		rxq.delete();
		tok_in <= 1'b1;
		tok_ep <= ep;
		@(posedge ref_clk);
		tok_in <= 1'b0;
		tok_ep <= ~ep;
		@(posedge ref_clk);
		ans_code = (tok_ans_valid === 1'b1) ? tok_ans_code : 2'h3;
		ans_len = {22'h000, tx_len};
		if (ans_code === 2'h1) begin
			for (int i = 0; i < ans_len; i++) begin
				tx_rd <= 1'b1;
				@(posedge ref_clk);
				tx_rd <= 1'b0;
				@(posedge ref_clk);
				if (tx_data_valid === 1'b1)
					rxq.push_back({24'h000000, tx_data});
				repeat (gap) @(posedge ref_clk);
			end
			tx_end <= 1'b1;
			tx_acked <= ack;
			@(posedge ref_clk);
			tx_end <= 1'b0;
			tx_acked <= ~ack;
			@(posedge ref_clk);
		end
	endtask
	task automatic out_tx(input logic [2:0] ep, input logic ok);
		tok_out <= 1'b1;
		tok_ep <= ep;
		for (int i = 0; i < txq.size(); i++) begin
			@(posedge ref_clk);
			tok_out <= 1'b0;
			rx_byte_valid <= 1'b1;
			rx_byte <= txq[i];
		end
		@(posedge ref_clk);
		tok_out <= 1'b0;
		rx_byte_valid <= 1'b0;
		rx_byte <= ~rx_byte;
		rx_end <= 1'b1;
		rx_ok <= ok;
		@(posedge ref_clk);
		rx_end <= 1'b0;
		rx_ok <= ~ok;
		tok_ep <= ~ep;
		@(posedge ref_clk);
		ans_code = (rx_ans_valid === 1'b1) ? rx_ans_code : 2'h3;
	endtask
endmodule // ufm_host_model
